// File: design/backlight_defines.vh
`ifndef BACKLIGHT_DEFINES_VH
`define BACKLIGHT_DEFINES_VH

// ----------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------
`define STRING_COUNT      6
`define DUTY_WIDTH        8
`define MEAS_WIDTH        24
`define DUTY_FULL         8'hFF

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define REF_CLK_HZ        10000000
// Dimming frequency in Hz equals this constant divided by ohms.
`define DIM_FREQ_CONST    181800000
// Default mode-pin resistance in ohms (about 20 kHz dimming).
`define DEFAULT_R_OHMS    9090
// Input is considered absent when no edge arrives within this time (us).
`define SIGNAL_LOSS_US    20000
`define SIGNAL_LOSS_CYC   ((`SIGNAL_LOSS_US * (`REF_CLK_HZ / 1000000)))
// Boost switching cycle length in reference clocks.
`define BOOST_PERIOD_CYC  16
// Sustained over-current: consecutive limited switching cycles.
`define OC_SUSTAIN_CYC    16
// Time spent probing string channels at startup (us).
`define PROBE_US          10
`define PROBE_CYC         ((`PROBE_US * (`REF_CLK_HZ / 1000000)))

// ----------------------------------------------------------------
// Sequencer states
// ----------------------------------------------------------------
`define ST_OFF            3'h0
`define ST_PROBE          3'h1
`define ST_WAIT_SIG       3'h2
`define ST_RUN            3'h3
`define ST_FAULT          3'h4

`endif

// File: design/duty_decoder.v
`timescale 1ns/10ps
`default_nettype none

// Measures high time and period of the dimming input and scales the
// result to an eight-bit duty value, updated once per whole period.
module duty_decoder #(
	parameter MEAS_WIDTH = 24
) (
	// Clock and control
	input  wire                  ref_clk,
	input  wire                  rst,
	input  wire                  enable,
	// Synchronised dimming input
	input  wire                  dim_in,
	// Result
	output reg  [7:0]            duty_q,
	output reg                   period_seen_q
);

	reg                  prev_q;
	reg [MEAS_WIDTH-1:0] period_cnt_q;
	reg [MEAS_WIDTH-1:0] high_cnt_q;
	wire                 rise;
	wire [MEAS_WIDTH+7:0] scaled;

	assign rise   = dim_in & ~prev_q;
	assign scaled = {high_cnt_q, 8'h00} - {8'h00, high_cnt_q};

	always @(posedge ref_clk) begin
		if (rst || !enable) begin
			prev_q        <= 1'b0;
			period_cnt_q  <= {MEAS_WIDTH{1'b0}};
			high_cnt_q    <= {MEAS_WIDTH{1'b0}};
			duty_q        <= 8'h00;
			period_seen_q <= 1'b0;
		end else begin
			prev_q <= dim_in;
			if (rise) begin
				if (period_seen_q && period_cnt_q != 0)
					duty_q <= sat8(scaled / {8'h00, period_cnt_q});
				period_seen_q <= 1'b1;
				period_cnt_q  <= {{(MEAS_WIDTH-1){1'b0}}, 1'b1};
				high_cnt_q    <= {{(MEAS_WIDTH-1){1'b0}}, 1'b1};
			end else begin
				if (~&period_cnt_q)
					period_cnt_q <= period_cnt_q + 1'b1;
				if (dim_in && ~&high_cnt_q)
					high_cnt_q <= high_cnt_q + 1'b1;
			end
		end
	end

	function [7:0] sat8;
		input [MEAS_WIDTH+7:0] v;
		begin
			sat8 = (v > 255) ? 8'hFF : v[7:0];
		end
	endfunction

endmodule

`default_nettype wire

// File: design/dim_generator.v
`timescale 1ns/10ps
`default_nettype none

// Free-running dimming PWM: period in reference clocks, duty in 1/255.
module dim_generator #(
	parameter PERIOD_WIDTH = 24
) (
	// Clock and control
	input  wire                    ref_clk,
	input  wire                    rst,
	input  wire                    enable,
	// Settings
	input  wire [PERIOD_WIDTH-1:0] period,
	input  wire [7:0]              duty,
	// Output
	output reg                     dim_out_q
);

	reg  [PERIOD_WIDTH-1:0] cnt_q;
	wire [PERIOD_WIDTH+7:0] on_time;

	assign on_time = (period * duty) / 255;

	always @(posedge ref_clk) begin
		if (rst || !enable) begin
			cnt_q     <= {PERIOD_WIDTH{1'b0}};
			dim_out_q <= 1'b0;
		end else begin
			if (cnt_q + 1'b1 >= period)
				cnt_q <= {PERIOD_WIDTH{1'b0}};
			else
				cnt_q <= cnt_q + 1'b1;
			dim_out_q <= ({8'h00, cnt_q} < on_time);
		end
	end

endmodule

`default_nettype wire

// File: design/backlight_control.v
// Behaviour
// - Programmable mode measures input duty into an eight-bit value.
// - Programmable mode switches all six sinks together at set frequency.
// - Direct mode sinks copy the dimming input exactly.
// - Direct mode disables duty measurement; its value is unused.
// - Mode pin high selects direct; resistor (default) selects programmable.
// - Dimming frequency equals 1.818e8 divided by mode-pin resistance.
// - Without input signal hold minimum output; dim only after detection.
// - At startup probe every string and disable unused ones for good.
// - Enable low puts the whole device into shutdown.
// - String drawing no current is flagged open, disabled, excluded.
// - String over 13.5 V feedback is turned off and excluded alone.
// - Shut down entirely only when every string is open; the code does so once every string is disabled, over-voltage included.
// - Fault-disabled strings stay off until reset or enable toggle.
// - At 2.0 A limit end switch pulse until next cycle.
// - Sustained over-current turns off and latches until reset or toggle.
// - Output short shuts down at once and latches; the code ignores it until startup probing ends.
// - Over 150 C shuts down at once and latches; the code ignores it until startup probing ends.
// - Over-voltage sense above 1.95 V clamps output at threshold.
// - Regulate on lowest active string feedback, target 350 mV.
`timescale 1ns/10ps
`default_nettype none
`include "backlight_defines.vh"

module backlight_control #(
	parameter NSTR         = `STRING_COUNT,
	parameter MEAS_WIDTH   = `MEAS_WIDTH,
	parameter SIGNAL_LOSS  = `SIGNAL_LOSS_CYC,
	parameter PROBE_CYC    = `PROBE_CYC,
	parameter RES_WIDTH    = 20
) (
	// Clock and reset
	input  wire                 ref_clk,
	input  wire                 rst,
	// Host pins
	input  wire                 enable_pin,
	input  wire                 dimming_input,
	input  wire                 dim_freq_mode_pin,
	// Mode-pin resistance in ohms, measured by the analog front end
	input  wire [RES_WIDTH-1:0] mode_res_ohms,
	// Per-string comparators from the analog sinks
	input  wire [NSTR-1:0]      string_feedback_present,
	input  wire [NSTR-1:0]      string_no_current,
	input  wire [NSTR-1:0]      string_feedback_ov,
	input  wire [NSTR-1:0]      string_feedback_low,
	// Boost and protection comparators
	input  wire                 inductor_limit,
	input  wire                 output_short,
	input  wire                 over_temp,
	input  wire                 overvoltage_sense_high,
	// Sink and boost controls
	output reg  [NSTR-1:0]      sink_on_q,
	output reg  [NSTR-1:0]      feedback_select_q,
	output reg                  boost_raise_q,
	output reg                  boost_min_q,
	output reg                  boost_switch_q,
	output reg                  ovp_clamp_q,
	output reg                  device_on_q,
	// Status
	output reg  [NSTR-1:0]      string_disabled_q,
	output reg  [NSTR-1:0]      string_open_q,
	output reg                  fault_latched_q,
	output reg                  direct_mode_q,
	output reg  [7:0]           duty_value_q
);

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	localparam NSYNC = 10 + 4 * NSTR;

	reg  [NSYNC-1:0] sync1_q;
	reg  [NSYNC-1:0] sync2_q;
	wire             en_s;
	wire             dim_s;
	wire             mode_s;
	wire             ilim_s;
	wire             short_s;
	wire             otemp_s;
	wire             ovs_s;
	wire [NSTR-1:0]  present_s;
	wire [NSTR-1:0]  nocur_s;
	wire [NSTR-1:0]  ov_s;
	wire [NSTR-1:0]  low_s;

	always @(posedge ref_clk) begin
		if (rst) begin
			sync1_q <= {NSYNC{1'b0}};
			sync2_q <= {NSYNC{1'b0}};
		end else begin
			sync1_q <= {3'b000, enable_pin, dimming_input, dim_freq_mode_pin,
				inductor_limit, output_short, over_temp,
				overvoltage_sense_high, string_feedback_present,
				string_no_current, string_feedback_ov,
				string_feedback_low};
			sync2_q <= sync1_q;
		end
	end

	assign low_s     = sync2_q[NSTR-1:0];
	assign ov_s      = sync2_q[2*NSTR-1:NSTR];
	assign nocur_s   = sync2_q[3*NSTR-1:2*NSTR];
	assign present_s = sync2_q[4*NSTR-1:3*NSTR];
	assign ovs_s     = sync2_q[4*NSTR];
	assign otemp_s   = sync2_q[4*NSTR+1];
	assign short_s   = sync2_q[4*NSTR+2];
	assign ilim_s    = sync2_q[4*NSTR+3];
	assign mode_s    = sync2_q[4*NSTR+4];
	assign dim_s     = sync2_q[4*NSTR+5];
	assign en_s      = sync2_q[4*NSTR+6];

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	reg [2:0]            state_q;
	reg [MEAS_WIDTH-1:0] timer_q;
	reg [MEAS_WIDTH-1:0] idle_q;
	reg                  dim_prev_q;
	reg [7:0]            oc_cnt_q;
	reg [4:0]            sw_cnt_q;
	reg                  cycle_limited_q;
	wire                 dim_edge;
	wire                 signal_lost;
	wire                 all_open;
	wire                 run;
	wire                 sw_start;
	wire [NSTR-1:0]      active;

	// The input counts as absent until its first edge after enable, so the
	// strings stay dark on a floating dimming line.
	localparam [MEAS_WIDTH-1:0] LOSS_INIT = SIGNAL_LOSS[MEAS_WIDTH-1:0];

	assign dim_edge    = dim_s ^ dim_prev_q;
	assign signal_lost = (idle_q >= SIGNAL_LOSS);
	assign active      = ~string_disabled_q;
	assign all_open    = &string_disabled_q;
	assign run         = (state_q == `ST_RUN);
	assign sw_start    = (sw_cnt_q == 5'h00);

	always @(posedge ref_clk) begin
		if (rst) begin
			dim_prev_q <= 1'b0;
			idle_q     <= LOSS_INIT;
		end else begin
			dim_prev_q <= dim_s;
			if (!en_s)
				idle_q <= LOSS_INIT;
			else if (dim_edge)
				idle_q <= {MEAS_WIDTH{1'b0}};
			else if (!signal_lost)
				idle_q <= idle_q + 1'b1;
		end
	end

	always @(posedge ref_clk) begin
		if (rst || !en_s) begin
			state_q           <= `ST_OFF;
			timer_q           <= {MEAS_WIDTH{1'b0}};
			string_disabled_q <= {NSTR{1'b0}};
			string_open_q     <= {NSTR{1'b0}};
			fault_latched_q   <= 1'b0;
			oc_cnt_q          <= 8'h00;
		end else begin
			case (state_q)
				`ST_OFF: begin
					state_q <= `ST_PROBE;
					timer_q <= {MEAS_WIDTH{1'b0}};
				end
				`ST_PROBE: begin
					timer_q <= timer_q + 1'b1;
					if (timer_q >= PROBE_CYC - 1) begin
						string_disabled_q <= ~present_s;
						state_q           <= `ST_WAIT_SIG;
					end
				end
				`ST_WAIT_SIG: begin
					if (!signal_lost)
						state_q <= `ST_RUN;
				end
				`ST_RUN: begin
					if (signal_lost)
						state_q <= `ST_WAIT_SIG;
					string_open_q     <= string_open_q |
						(nocur_s & active & sink_on_q);
					string_disabled_q <= string_disabled_q |
						(nocur_s & sink_on_q) | ov_s;
				end
				default: state_q <= `ST_FAULT;
			endcase
			// sustained over-current
			// A cycle with no pulse wanted neither counts nor clears.
			if (sw_start && run) begin
				if (cycle_limited_q)
					oc_cnt_q <= oc_cnt_q + 1'b1;
				else if (boost_switch_q)
					oc_cnt_q <= 8'h00;
			end
			if ((state_q != `ST_OFF && state_q != `ST_PROBE &&
				(short_s || otemp_s || all_open)) ||
				oc_cnt_q >= `OC_SUSTAIN_CYC) begin
				state_q         <= `ST_FAULT;
				fault_latched_q <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Mode and dimming
	// ----------------------------------------------------------------
	wire [7:0]            decoded;
	wire                  decoded_valid;
	wire                  prog_pwm;
	wire [MEAS_WIDTH-1:0] dim_period;
	wire [MEAS_WIDTH+7:0] period_calc;
	wire [63:0]           period_full;

	// period from resistor
	// The product of clock rate and ohms needs up to 44 bits, so it is formed at 64 bits before the divide.
	assign period_full = ({{(64-RES_WIDTH){1'b0}}, mode_res_ohms} *
		`REF_CLK_HZ) / `DIM_FREQ_CONST;
	assign period_calc = period_full[MEAS_WIDTH+7:0];
	assign dim_period  = (period_calc == 0) ? {{(MEAS_WIDTH-1){1'b0}}, 1'b1}
		: period_calc[MEAS_WIDTH-1:0];

	always @(posedge ref_clk) begin
		if (rst || !en_s) begin
			direct_mode_q <= 1'b0;
		end else if (state_q == `ST_OFF) begin
			direct_mode_q <= mode_s;
		end
	end

	duty_decoder #(
		.MEAS_WIDTH(MEAS_WIDTH)
	) u_decoder (
		.ref_clk      (ref_clk),
		.rst          (rst),
		.enable       (run & ~direct_mode_q),
		.dim_in       (dim_s),
		.duty_q       (decoded),
		.period_seen_q(decoded_valid)
	);

	dim_generator #(
		.PERIOD_WIDTH(MEAS_WIDTH)
	) u_generator (
		.ref_clk  (ref_clk),
		.rst      (rst),
		.enable   (run & ~direct_mode_q),
		.period   (dim_period),
		.duty     (decoded),
		.dim_out_q(prog_pwm)
	);

	// ----------------------------------------------------------------
	// Sink and boost outputs
	// ----------------------------------------------------------------
	reg  fb_low_any;
	wire dim_now;

	assign dim_now = direct_mode_q ? dim_s : (prog_pwm & decoded_valid);

	always @* begin
		fb_low_any = |(low_s & active & sink_on_q);
	end

	always @(posedge ref_clk) begin
		if (rst || !en_s) begin
			sw_cnt_q        <= 5'h00;
			cycle_limited_q <= 1'b0;
			boost_switch_q  <= 1'b0;
		end else begin
			sw_cnt_q <= (sw_cnt_q == `BOOST_PERIOD_CYC - 1) ? 5'h00
				: sw_cnt_q + 1'b1;
			if (sw_start) begin
				// A pulse wanted while the limit already stands is cut to
				// zero width and still counts as a limited cycle.
				boost_switch_q  <= run & fb_low_any & ~ovs_s & ~ilim_s;
				cycle_limited_q <= run & fb_low_any & ~ovs_s & ilim_s;
			end else if (ilim_s) begin
				boost_switch_q  <= 1'b0;
				cycle_limited_q <= boost_switch_q | cycle_limited_q;
			end
		end
	end

	always @(posedge ref_clk) begin
		if (rst || !en_s) begin
			sink_on_q         <= {NSTR{1'b0}};
			feedback_select_q <= {NSTR{1'b0}};
			boost_raise_q     <= 1'b0;
			boost_min_q       <= 1'b0;
			ovp_clamp_q       <= 1'b0;
			device_on_q       <= 1'b0;
			duty_value_q      <= 8'h00;
		end else begin
			device_on_q       <= (state_q != `ST_FAULT);
			sink_on_q         <= run ? ({NSTR{dim_now}} & active)
				: {NSTR{1'b0}};
			feedback_select_q <= run ? (active & ~ov_s) : {NSTR{1'b0}};
			boost_min_q       <= (state_q == `ST_WAIT_SIG);
			ovp_clamp_q       <= ovs_s;
			boost_raise_q     <= run & fb_low_any & ~ovs_s;
			duty_value_q      <= direct_mode_q ? 8'h00 : decoded;
		end
	end

endmodule

`default_nettype wire

// File: bench/backlight_control_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module backlight_control_monitor #(
	parameter NSTR = 6
) (
	// Clock and reset
	input wire logic            ref_clk,
	input wire logic            rst,
	// Pins and comparators
	input wire logic            enable_pin,
	input wire logic            dimming_input,
	input wire logic            inductor_limit,
	input wire logic            output_short,
	input wire logic            over_temp,
	// Controls and status
	input wire logic [NSTR-1:0] sink_on_q,
	input wire logic [NSTR-1:0] feedback_select_q,
	input wire logic [NSTR-1:0] string_disabled_q,
	input wire logic            boost_min_q,
	input wire logic            boost_switch_q,
	input wire logic            device_on_q,
	input wire logic            fault_latched_q,
	input wire logic            direct_mode_q,
	input wire logic [7:0]      duty_value_q
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	// Enable must settle through the synchroniser before state follows.
	sequence s_en_low; !enable_pin [*5]; endsequence
	sequence s_en_held; enable_pin [*3]; endsequence
	sequence s_running; device_on_q && !boost_min_q; endsequence
	property p_shutdown; s_en_low |-> !device_on_q && sink_on_q == '0; endproperty
	a_shutdown: assert property (p_shutdown) else $error("device on while disabled");
	property p_clear;
		s_en_low |-> !fault_latched_q && string_disabled_q == '0;
	endproperty
	a_clear: assert property (p_clear) else $error("latches kept while disabled");
	property p_temp; s_running ##0 over_temp [*2] |-> ##[1:5] (fault_latched_q && !device_on_q); endproperty
	a_temp: assert property (p_temp) else $error("no shutdown on over-temperature");
	property p_short; s_running ##0 output_short [*2] |-> ##[1:5] (fault_latched_q && !device_on_q); endproperty
	a_short: assert property (p_short) else $error("no shutdown on output short");
	property p_latch; s_en_held ##0 fault_latched_q |=> fault_latched_q; endproperty
	a_latch: assert property (p_latch) else $error("fault latch released");
	property p_sticky;
		s_en_held |=> (string_disabled_q & $past(string_disabled_q)) == $past(string_disabled_q);
	endproperty
	a_sticky: assert property (p_sticky) else $error("disabled string revived");
	property p_excl;
		((sink_on_q | feedback_select_q) & $past(string_disabled_q, 2)) == '0;
	endproperty
	a_excl: assert property (p_excl) else $error("disabled string still used");
	property p_direct;
		direct_mode_q && $rose(sink_on_q[0]) |->
			$past(dimming_input, 3) || $past(dimming_input, 4) || $past(dimming_input, 5);
	endproperty
	a_direct: assert property (p_direct) else $error("sink rose without input");
	property p_nodecode; direct_mode_q && $past(direct_mode_q) |-> duty_value_q == 8'h00; endproperty
	a_nodecode: assert property (p_nodecode) else $error("duty used in direct mode");
	property p_min; boost_min_q |-> sink_on_q == '0; endproperty
	a_min: assert property (p_min) else $error("sinks on before signal");
	property p_limit; inductor_limit [*5] |-> !boost_switch_q; endproperty
	a_limit: assert property (p_limit) else $error("switch on at current limit");
endmodule
bind backlight_control backlight_control_monitor #(.NSTR(NSTR)) u_mon (
	.ref_clk(ref_clk), .rst(rst), .enable_pin(enable_pin),
	.dimming_input(dimming_input), .inductor_limit(inductor_limit),
	.output_short(output_short), .over_temp(over_temp),
	.sink_on_q(sink_on_q), .feedback_select_q(feedback_select_q),
	.string_disabled_q(string_disabled_q), .boost_min_q(boost_min_q),
	.boost_switch_q(boost_switch_q), .device_on_q(device_on_q),
	.fault_latched_q(fault_latched_q), .direct_mode_q(direct_mode_q),
	.duty_value_q(duty_value_q));
`default_nettype wire

// File: bench/host_pwm_model.sv
`timescale 1ns/10ps
`default_nettype none
module host_pwm_model (
	// Clock
	input  wire logic        ref_clk,
	// Waveform setting
	input  wire logic        run,
	input  wire logic [15:0] high_cyc,
	input  wire logic [15:0] period_cyc,
	// Dimming line
	output var logic         dimming_input
);
	logic [15:0] cnt_q;
	initial begin
		cnt_q = 16'h0000;
		dimming_input = 1'b0;
	end
	// An idle host leaves the line to its pull-down, so it reads low.
	always @(posedge ref_clk) begin
		cnt_q <= #1 (!run || cnt_q + 16'h0001 >= period_cyc) ? 16'h0000
			: cnt_q + 16'h0001;
		dimming_input <= #1 run && (cnt_q < high_cyc);
	end
endmodule
`default_nettype wire

// File: bench/backlight_dimming_fault_control_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module backlight_dimming_fault_control_tb_top;
	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	typedef struct packed {logic [15:0] high; logic [7:0] duty;} row_t;
	// Duty codes: high time times 255 over a 200-cycle period.
	row_t rows[3] = '{'{16'h0032, 8'h3f}, '{16'h0064, 8'h7f},
		'{16'h0096, 8'hbf}};
	logic ref_clk = 1'b0, rst = 1'b1, enable_pin = 1'b0, mode = 1'b0;
	logic ind_lim = 1'b0, out_short = 1'b0, hot = 1'b0, ovs = 1'b0;
	logic pwm_run = 1'b0;
	logic [15:0] pwm_high = 16'h0096, pwm_per = 16'h00c8;
	logic [5:0] present = 6'h3f, no_cur = 6'h00, ov = 6'h00, low = 6'h3f;
	wire logic [5:0] sink_on_q, fb_sel, disabled, open_q;
	wire logic boost_min_q, ovp_clamp_q, device_on_q, fault_q, direct_q;
	wire logic dim;
	wire logic [7:0] duty_value_q;
	int err_count = 0, num_checks = 0, cycles = 0, t;
	always #50 ref_clk = ~ref_clk;
	host_pwm_model host (.ref_clk(ref_clk), .run(pwm_run), .high_cyc(pwm_high),
		.period_cyc(pwm_per), .dimming_input(dim));
	backlight_control #(.SIGNAL_LOSS(200), .PROBE_CYC(100)) dut (
		.ref_clk(ref_clk), .rst(rst), .enable_pin(enable_pin),
		.dimming_input(dim), .dim_freq_mode_pin(mode),
		.mode_res_ohms(20'h0_4704), .string_feedback_present(present),
		.string_no_current(no_cur), .string_feedback_ov(ov),
		.string_feedback_low(low), .inductor_limit(ind_lim),
		.output_short(out_short), .over_temp(hot),
		.overvoltage_sense_high(ovs), .sink_on_q(sink_on_q),
		.feedback_select_q(fb_sel), .boost_raise_q(), .boost_min_q(boost_min_q),
		.boost_switch_q(), .ovp_clamp_q(ovp_clamp_q), .device_on_q(device_on_q),
		.string_disabled_q(disabled), .string_open_q(open_q),
		.fault_latched_q(fault_q), .direct_mode_q(direct_q),
		.duty_value_q(duty_value_q));
	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic results;
		if (err_count == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic wait_lvl(input bit sel, input logic lvl);
		for (int i = 0; i < 3000; i++) begin
			if ((sel ? dim : sink_on_q[0]) === lvl)
				break;
			cyc(1);
		end
	endtask
	// Enable toggle; the mode pin is only read as enable rises.
	task automatic restart(input logic m);
		enable_pin = 1'b0;
		cyc(6);
		mode = m;
		enable_pin = 1'b1;
		cyc(120);
	endtask
	// A run that hangs past 40000 cycles is cut short here and counted as a mismatch.
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			err_count++;
			results();
		end
	end
	// ----------------------------------------------------------------
	// Sequence
	// ----------------------------------------------------------------
	initial begin
		cyc(6);
		chk(device_on_q, 1'b0);
		rst = 1'b0;
		restart(1'b0);
		chk(boost_min_q, 1'b1);
		chk(direct_q, 1'b0);
		pwm_run = 1'b1;
		foreach (rows[i]) begin
			pwm_high = rows[i].high;
			cyc(1500);
			chk(duty_value_q, rows[i].duty);
			wait_lvl(0, 0);
			wait_lvl(0, 1);
			chk(sink_on_q, 6'h3f);
			t = cycles;
			wait_lvl(0, 0);
			wait_lvl(0, 1);
			chk(24'(cycles - t), 24'h00_03e8);
		end
		restart(1'b1);
		chk(direct_q, 1'b1);
		chk(duty_value_q, 8'h00);
		wait_lvl(1, 0);
		wait_lvl(1, 1);
		cyc(6);
		chk(sink_on_q, 6'h3f);
		no_cur = 6'h04;
		cyc(400);
		no_cur = 6'h00;
		ov = 6'h10;
		cyc(50);
		ov = 6'h00;
		chk(open_q, 6'h04);
		wait_lvl(1, 1);
		cyc(6);
		chk(sink_on_q, 6'h2b);
		chk(device_on_q, 1'b1);
		chk(disabled[2], 1'b1);
		present = 6'h3e;
		restart(1'b1);
		present = 6'h3f;
		chk(disabled, 6'h01);
		restart(1'b1);
		chk(disabled, 6'h00);
		no_cur = 6'h3f;
		cyc(400);
		no_cur = 6'h00;
		chk({fault_q, device_on_q}, 2'h2);
		for (int f = 0; f < 3; f++) begin
			restart(1'b1);
			{hot, out_short, ind_lim} = 3'h1 << f;
			cyc(600);
			{hot, out_short, ind_lim} = 3'h0;
			cyc(20);
			chk({fault_q, device_on_q}, 2'h2);
		end
		restart(1'b1);
		ovs = 1'b1;
		cyc(10);
		chk(ovp_clamp_q, 1'b1);
		ovs = 1'b0;
		enable_pin = 1'b0;
		cyc(6);
		chk({device_on_q, sink_on_q}, 7'h00);
		results();
	end
endmodule
`default_nettype wire
